// >>> rtl/vrr_pkg.sv
// package: register map, field layout, limits and bus states of the voltage result registers
package vrr_pkg;

  // register byte addresses (low byte of each 16-bit word)
  localparam logic [7:0]  ADDR_PMID      = 8'h2E;
  localparam logic [7:0]  ADDR_VBAT      = 8'h30;
  localparam logic [7:0]  ADDR_VSYS      = 8'h32;
  localparam logic [15:0] RESET_WORD     = 16'h0000;

  // field layout
  localparam int          PMID_LSB       = 2;
  localparam int          PMID_W         = 13;
  localparam int          VOLT12_LSB     = 1;
  localparam int          VOLT12_W       = 12;

  // full-scale codes and step sizes in microvolts
  localparam logic [15:0] PMID_MAX       = 16'h11B6;
  localparam logic [15:0] VOLT12_MAX     = 16'h0AF0;
  localparam int          PMID_STEP_UV   = 3970;
  localparam int          VOLT12_STEP_UV = 1990;
  localparam int          PMID_FS_MV     = 18000;
  localparam int          VOLT12_FS_MV   = 5572;

  // serial target address: value is arbitrary
  localparam logic [6:0]  TARGET_ADDR    = 7'h3C;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR   = 7'h08,
    ST_WACK = 7'h10,
    ST_RD   = 7'h20,
    ST_MACK = 7'h40
  } vrr_state_t;

endpackage : vrr_pkg

// >>> rtl/vrr_result_if.sv
// interface: clamped result fields passed from the capture stage to the register map
`timescale 1ns/1ps
interface vrr_result_if;
  logic [12:0] pmid_voltage_reading;
  logic [11:0] battery_voltage_reading;
  logic [11:0] system_voltage_reading;

  modport src (output pmid_voltage_reading, output battery_voltage_reading,
               output system_voltage_reading);
  modport snk (input pmid_voltage_reading, input battery_voltage_reading,
               input system_voltage_reading);
endinterface : vrr_result_if

// >>> rtl/vrr_capture.sv
// module: captures converter results, clamps them at full scale, updates each field whole
`timescale 1ns/1ps
module vrr_capture
  import vrr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // converter results, codes in field steps
  input  wire logic [15:0] pmid_code_i,
  input  wire logic        pmid_done_i,
  input  wire logic [15:0] vbat_code_i,
  input  wire logic        vbat_done_i,
  input  wire logic [15:0] vsys_code_i,
  input  wire logic        vsys_done_i,
  // clamped fields
  vrr_result_if.src        res
);
  import vrr_pkg::*;

  logic [12:0] pmid;
  logic [11:0] vbat;
  logic [11:0] vsys;
  logic [12:0] next_pmid;
  logic [11:0] next_vbat;
  logic [11:0] next_vsys;
  logic [15:0] pmid_cl;
  logic [15:0] vbat_cl;
  logic [15:0] vsys_cl;

  function automatic logic [15:0] clamp(input logic [15:0] raw, input logic [15:0] top);
    clamp = (raw > top) ? top : raw;
  endfunction : clamp

  // clamp at full width first, so the slice below never wraps a large code
  assign pmid_cl = clamp(pmid_code_i, PMID_MAX);
  assign vbat_cl = clamp(vbat_code_i, VOLT12_MAX);
  assign vsys_cl = clamp(vsys_code_i, VOLT12_MAX);

  always_comb begin
    next_pmid = pmid;
    next_vbat = vbat;
    next_vsys = vsys;
    // a field only changes when a whole conversion lands, never piecewise
    if (pmid_done_i) begin
      next_pmid = pmid_cl[12:0];
    end
    if (vbat_done_i) begin
      next_vbat = vbat_cl[11:0];
    end
    if (vsys_done_i) begin
      next_vsys = vsys_cl[11:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pmid <= 13'h0000;
      vbat <= 12'h000;
      vsys <= 12'h000;
    end else begin
      pmid <= next_pmid;
      vbat <= next_vbat;
      vsys <= next_vsys;
    end
  end

  assign res.pmid_voltage_reading    = pmid;
  assign res.battery_voltage_reading = vbat;
  assign res.system_voltage_reading  = vsys;

  a_pmid_clamp_top: assert property (@(posedge clk_i) disable iff (rst_i)
    pmid_done_i && pmid_code_i >= PMID_MAX |=> pmid == PMID_MAX[12:0])
    else $error("pmid field not clamped at full scale");
  a_pmid_step_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    pmid_done_i && pmid_code_i < PMID_MAX |=> pmid == $past(pmid_code_i[12:0]))
    else $error("pmid field does not carry the code one to one");
  a_vbat_clamp_top: assert property (@(posedge clk_i) disable iff (rst_i)
    vbat_done_i |=> vbat == ($past(vbat_code_i) > VOLT12_MAX ? VOLT12_MAX[11:0]
                                                              : $past(vbat_code_i[11:0])))
    else $error("battery field wrong after conversion");
  a_vsys_clamp_top: assert property (@(posedge clk_i) disable iff (rst_i)
    vsys_done_i |=> vsys == ($past(vsys_code_i) > VOLT12_MAX ? VOLT12_MAX[11:0]
                                                              : $past(vsys_code_i[11:0])))
    else $error("system field wrong after conversion");
  a_fields_reset_zero: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i && !$past(pmid_done_i) && !$past(vbat_done_i)
    && !$past(vsys_done_i) |-> pmid == 13'h0000 && vbat == 12'h000 && vsys == 12'h000)
    else $error("result fields not zero after reset");
  a_fields_hold_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !pmid_done_i && !vbat_done_i && !vsys_done_i |=> $stable(pmid) && $stable(vbat)
    && $stable(vsys))
    else $error("result field moved without a conversion");

endmodule : vrr_capture

// >>> rtl/vrr_top.sv
// module: voltage result registers read by a host over the two-wire serial target
`timescale 1ns/1ps
module vrr_top
  import vrr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // converter results
  input  wire logic [15:0] pmid_code_i,
  input  wire logic        pmid_done_i,
  input  wire logic [15:0] vbat_code_i,
  input  wire logic        vbat_done_i,
  input  wire logic [15:0] vsys_code_i,
  input  wire logic        vsys_done_i,
  // serial bus pins, data is open drain
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);
  import vrr_pkg::*;

  vrr_result_if res ();

  vrr_capture u_capture (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .pmid_code_i (pmid_code_i),
    .pmid_done_i (pmid_done_i),
    .vbat_code_i (vbat_code_i),
    .vbat_done_i (vbat_done_i),
    .vsys_code_i (vsys_code_i),
    .vsys_done_i (vsys_done_i),
    .res         (res.src)
  );

  vrr_state_t  state;
  vrr_state_t  next_state;
  logic        scl_q;
  logic        sda_q;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic        rw;
  logic        next_rw;
  logic        have_ptr;
  logic        next_have_ptr;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic [7:0]  tx;
  logic [7:0]  next_tx;
  logic        mack;
  logic        next_mack;
  logic [15:0] shadow;
  logic [15:0] next_shadow;
  logic [7:0]  shadow_addr;
  logic [7:0]  next_shadow_addr;
  logic        oe;
  logic        next_oe;

  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic [7:0]  ld_addr;
  logic [15:0] ld_word;
  logic [7:0]  ld_byte;

  // reserved bits are forced to zero when the word is assembled
  function automatic logic [15:0] reg_word(input logic [7:0] a);
    logic [7:0] wa;
    wa = {a[7:1], 1'b0};
    unique case (wa)
      ADDR_PMID: reg_word = {1'b0, res.pmid_voltage_reading, 2'b00};
      ADDR_VBAT: reg_word = {3'b000, res.battery_voltage_reading, 1'b0};
      ADDR_VSYS: reg_word = {3'b000, res.system_voltage_reading, 1'b0};
      default:   reg_word = RESET_WORD;
    endcase
  endfunction : reg_word

  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;

  // byte to present next: the low byte snapshots the whole word, so the high
  // byte read right after it comes from the same conversion
  always_comb begin
    ld_addr          = (state == ST_MACK) ? ptr + 8'h01 : ptr;
    ld_word          = reg_word(ld_addr);
    next_shadow      = shadow;
    next_shadow_addr = shadow_addr;
    if (!ld_addr[0]) begin
      ld_byte = ld_word[7:0];
    end else if (shadow_addr == ld_addr - 8'h01) begin
      ld_byte = shadow[15:8];
    end else begin
      ld_byte = ld_word[15:8];
    end
    if ((state == ST_AACK && rw && fall) || (state == ST_MACK && mack && fall)) begin
      if (!ld_addr[0]) begin
        next_shadow      = ld_word;
        next_shadow_addr = ld_addr;
      end
    end
  end

  always_comb begin
    next_state    = state;
    next_sh       = sh;
    next_cnt      = cnt;
    next_rw       = rw;
    next_have_ptr = have_ptr;
    next_ptr      = ptr;
    next_tx       = tx;
    next_mack     = mack;
    next_oe       = oe;
    if (start) begin
      next_state    = ST_ADDR;
      next_cnt      = 4'h0;
      next_oe       = 1'b0;
      next_have_ptr = 1'b0;
    end else if (stop) begin
      next_state = ST_IDLE;
      next_oe    = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WR: begin
          if (rise) begin
            next_sh  = {sh[6:0], sda_i};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == BITS_PER_BYTE) begin
            if (state == ST_ADDR) begin
              if (sh[7:1] == TARGET_ADDR) begin
                next_rw    = sh[0];
                next_state = ST_AACK;
                next_oe    = 1'b1;
              end else begin
                next_state = ST_IDLE;
              end
            end else begin
              // data bytes written to these read-only words are acknowledged and dropped
              if (!have_ptr) begin
                next_ptr      = sh;
                next_have_ptr = 1'b1;
              end else begin
                next_ptr = ptr + 8'h01;
              end
              next_state = ST_WACK;
              next_oe    = 1'b1;
            end
          end
        end
        ST_AACK: begin
          if (fall) begin
            next_cnt = 4'h0;
            if (rw) begin
              next_tx    = ld_byte;
              next_oe    = ~ld_byte[7];
              next_state = ST_RD;
            end else begin
              next_oe    = 1'b0;
              next_state = ST_WR;
            end
          end
        end
        ST_WACK: begin
          if (fall) begin
            next_oe    = 1'b0;
            next_cnt   = 4'h0;
            next_state = ST_WR;
          end
        end
        ST_RD: begin
          if (rise) begin
            next_cnt = cnt + 4'h1;
          end else if (fall) begin
            if (cnt == BITS_PER_BYTE) begin
              next_oe    = 1'b0;
              next_state = ST_MACK;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_oe = ~tx[6];
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            next_mack = ~sda_i;
          end else if (fall) begin
            if (mack) begin
              next_ptr   = ld_addr;
              next_tx    = ld_byte;
              next_oe    = ~ld_byte[7];
              next_cnt   = 4'h0;
              next_state = ST_RD;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= ST_IDLE;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      sh          <= 8'h00;
      cnt         <= 4'h0;
      rw          <= 1'b0;
      have_ptr    <= 1'b0;
      ptr         <= 8'h00;
      tx          <= 8'h00;
      mack        <= 1'b0;
      shadow      <= RESET_WORD;
      shadow_addr <= 8'hFF;
      oe          <= 1'b0;
      sda_o       <= 1'b0;
      sda_oe_o    <= 1'b0;
    end else begin
      state       <= next_state;
      scl_q       <= scl_i;
      sda_q       <= sda_i;
      sh          <= next_sh;
      cnt         <= next_cnt;
      rw          <= next_rw;
      have_ptr    <= next_have_ptr;
      ptr         <= next_ptr;
      tx          <= next_tx;
      mack        <= next_mack;
      shadow      <= next_shadow;
      shadow_addr <= next_shadow_addr;
      oe          <= next_oe;
      sda_o       <= 1'b0;
      sda_oe_o    <= next_oe;
    end
  end

  a_pmid_word_layout: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_RD && cnt == 4'h0 && ptr == ADDR_PMID |-> tx[1:0] == 2'b00)
    else $error("pmid low byte reserved bits not zero");
  a_vsys_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_RD && cnt == 4'h0 && ptr == ADDR_VSYS + 8'h01 |-> tx[7:5] == 3'b000)
    else $error("system word reserved top bits not zero");
  a_read_same_conv: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_RD && cnt == 4'h0 && ptr[0] && shadow_addr == ptr - 8'h01
    |-> tx == shadow[15:8])
    else $error("high byte not taken from the snapshot of its word");

endmodule : vrr_top

// >>> tb/vrr_host_model.sv
// partner model: serial bus host that reads the result words
`timescale 1ns/1ps
module vrr_host_model
  import vrr_pkg::*;
(
  // clock
  input  wire logic clk_i,
  // bus lines, sda released means pulled up
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  import vrr_pkg::*;

  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // four clocks a phase keeps every scl phase above the three-cycle floor
  task automatic wait_half();
    repeat (4) @(posedge clk_i);
  endtask : wait_half

  // sda only moves while scl is low; the slot ends with scl high
  task automatic bit_slot(input logic tx, output logic rx);
    scl_o <= 1'b0;
    wait_half();
    sda_low_o <= ~tx;
    wait_half();
    scl_o <= 1'b1;
    wait_half();
    rx = sda_i;
  endtask : bit_slot

  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], d);
    end
    bit_slot(1'b1, nak);
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, b[i]);
    end
    bit_slot(last, d);
  endtask : recv_byte

  task automatic stop_cond();
    logic d;
    bit_slot(1'b0, d);
    sda_low_o <= 1'b0;
    wait_half();
  endtask : stop_cond

  // pointer write, repeated start, low byte read and acked
  task automatic rd_lo(input logic [6:0] dev, input logic [7:0] a,
                       output logic [7:0] lo, output logic nak);
    logic n0, n1, n2, d;
    sda_low_o <= 1'b1;
    wait_half();
    send_byte({dev, 1'b0}, n0);
    send_byte(a, n1);
    bit_slot(1'b1, d);
    sda_low_o <= 1'b1;
    wait_half();
    send_byte({dev, 1'b1}, n2);
    recv_byte(1'b0, lo);
    nak = n0 | n1 | n2;
  endtask : rd_lo

  task automatic rd_hi(output logic [7:0] hi);
    recv_byte(1'b1, hi);
    stop_cond();
  endtask : rd_hi

  task automatic wr_byte(input logic [7:0] a, input logic [7:0] v);
    logic d;
    sda_low_o <= 1'b1;
    wait_half();
    send_byte({TARGET_ADDR, 1'b0}, d);
    send_byte(a, d);
    send_byte(v, d);
    stop_cond();
  endtask : wr_byte
endmodule : vrr_host_model

// >>> tb/tb_voltage_adc_result_regs.sv
// testbench: result words read back over the serial bus
`timescale 1ns/1ps
module tb_voltage_adc_result_regs;
  import vrr_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic [15:0] code_q [3];
  logic        done_q [3];
  logic        scl;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe_o;
  wire         sda = (sda_oe_o ? sda_o : 1'b1) & ~sda_low;
  int          bad_count;
  int          check_count;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic        nak;

  vrr_top vrr_top_i (
    .clk_i(clk_i), .rst_i(rst_i),
    .pmid_code_i(code_q[0]), .pmid_done_i(done_q[0]),
    .vbat_code_i(code_q[1]), .vbat_done_i(done_q[1]),
    .vsys_code_i(code_q[2]), .vsys_done_i(done_q[2]),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
  );

  vrr_host_model vrr_host_model_i (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic final_report();
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : do_reset

  // static task: its channel index may steer a non-blocking assignment
  task load(input int ch, input logic [15:0] c);
    code_q[ch] <= c;
    done_q[ch] <= 1'b1;
    @(posedge clk_i);
    done_q[ch] <= 1'b0;
    @(posedge clk_i);
  endtask : load

  task automatic read_word(input logic [7:0] a, input logic [15:0] exp);
    vrr_host_model_i.rd_lo(TARGET_ADDR, a, lo, nak);
    vrr_host_model_i.rd_hi(hi);
    check({15'h0000, nak}, 16'h0000);
    check({hi, lo}, exp);
  endtask : read_word

  task automatic load_read(input int ch, input logic [15:0] c, input logic [15:0] exp);
    load(ch, c);
    read_word(ADDR_PMID + 8'(2 * ch), exp);
  endtask : load_read

  task automatic zero_all();
    read_word(ADDR_PMID, RESET_WORD);
    read_word(ADDR_VBAT, RESET_WORD);
    read_word(ADDR_VSYS, RESET_WORD);
  endtask : zero_all

  initial begin
    bad_count   = 0;
    check_count = 0;
    rst_i       = 1'b1;
    for (int i = 0; i < 3; i++) begin
      code_q[i] = 16'h0000;
      done_q[i] = 1'b0;
    end
    do_reset();
    zero_all();
    load_read(0, 16'h0001, 16'h0004);
    load_read(0, 16'h11B5, 16'h46D4);
    load_read(0, 16'h11B6, 16'h46D8);
    load_read(0, 16'hFFFF, 16'h46D8);
    load_read(1, 16'h0ABC, 16'h1578);
    load_read(1, 16'h0AF1, 16'h15E0);
    load_read(2, 16'h0555, 16'h0AAA);
    load_read(2, 16'hFFFF, 16'h15E0);
    read_word(ADDR_PMID, 16'h46D8);
    // the high byte must come from the conversion that gave the low byte
    load(0, 16'h0FFF);
    vrr_host_model_i.rd_lo(TARGET_ADDR, ADDR_PMID, lo, nak);
    load(0, 16'h0001);
    vrr_host_model_i.rd_hi(hi);
    check({hi, lo}, 16'h3FFC);
    read_word(ADDR_PMID, 16'h0004);
    // writes are ignored, the field stays read-only
    vrr_host_model_i.wr_byte(ADDR_PMID, 8'hFF);
    read_word(ADDR_PMID, 16'h0004);
    read_word(8'h40, 16'h0000);
    // a foreign address gets no acknowledge and the line stays pulled up
    vrr_host_model_i.rd_lo(TARGET_ADDR ^ 7'h01, ADDR_VBAT, lo, nak);
    vrr_host_model_i.rd_hi(hi);
    check({nak, 7'h00, lo}, 16'h80FF);
    read_word(ADDR_VBAT, 16'h15E0);
    do_reset();
    zero_all();
    final_report();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
endmodule : tb_voltage_adc_result_regs
